// ---- hw/reading_math_map.vh ----
// Register offsets, field codes and constants of the reading math post-processor
`ifndef READING_MATH_MAP_VH
`define READING_MATH_MAP_VH
// Byte offsets on the register bus
`define RM_CTRL      8'h00
`define RM_CMD       8'h04
`define RM_CFG_IDX   8'h08
`define RM_UNIT      8'h0c
`define RM_SCALE_LO  8'h10
`define RM_SCALE_HI  8'h14
`define RM_OFFS_LO   8'h18
`define RM_OFFS_HI   8'h1c
`define RM_REF_LO    8'h20
`define RM_REF_HI    8'h24
`define RM_ENTRY     8'h28
`define RM_ENTRY_CTL 8'h2c
`define RM_RES_LO    8'h30
`define RM_RES_HI    8'h34
`define RM_FRESH_LO  8'h38
`define RM_FRESH_HI  8'h3c
`define RM_STATUS    8'h40
// Command bits
`define RM_CMD_ACQ     0
`define RM_CMD_RST     1
`define RM_CMD_PRESET  2
`define RM_CMD_MENU    3
`define RM_CMD_TOGSIGN 4
`define RM_CMD_LDSCALE 5
`define RM_CMD_LDOFFS  6
`define RM_CMD_LDREF   7
// Calculation selector codes
`define RM_SEL_NONE  2'h0
`define RM_SEL_SCALE_OFFSET 2'h1
`define RM_SEL_PERC  2'h2
`define RM_SEL_RECIP 2'h3
// Number format: signed Q48.16
`define RM_FRAC      16
`define RM_ONE       64'h0000_0000_0001_0000
`define RM_ZERO      64'h0000_0000_0000_0000
`define RM_LIM       64'h0000_ffff_ffff_0000
// Unit characters
`define RM_UNIT_DEF  8'h58
`define RM_UNIT_RCP  8'h52
`define RM_UNIT_PCT  8'h25
// Error codes (16-bit two's complement)
`define RM_ERR_NONE  16'h0000
`define RM_ERR_EXEC  16'hff38
`define RM_ERR_STALE 16'hff1a
// Divider length in cycles
`define RM_DIV_LEN   7'h60
`endif

// ---- hw/reading_math_postprocessor.v ----
// Reading math post-processor: scale/offset, percent, reciprocal
`default_nettype none
`include "reading_math_map.vh"
// Notes on behaviour
// - percent is (input-ref)/ref times 100
// - rel-corrected reading feeds percent and reciprocal
// - reference clamped to 4294967295, defaults 1
// - percent sign follows input above/below ref
// - reciprocal is 1/input, unit fixed R
// - entry multiplier 0.001/1/1000/1e6, sign toggles
// - enabled shared (entry 0) calculation lights indicator, all functions
// - menu again while active disables calculation
// - selector none/scale/percent/reciprocal, default percent
// - scale/offset clamped, defaults 1 and 0
// - enable on at reset command, off at preset
// - acquire loads reading, else error -200
// - reference readback returns last set value
// - latest result repeats, triggers nothing
// - fresh result once, repeat raises -230
// - none or disabled returns raw reading
// - simple scan shared, advanced per-channel setup
// - front inputs compute without closed channel
// - scale mode is scale times reading plus offset
module reading_math_postprocessor #(
   parameter NCH = 4,                       // Advanced scan channels
   parameter IW  = 3                        // Config index width
) (
   input  wire        clk_in,
   input  wire        rst_n_in,
   input  wire [7:0]  address_in,           // Avalon byte address
   input  wire        read_in,
   input  wire        write_in,
   input  wire [31:0] writedata_in,
   input  wire [3:0]  byteenable_in,
   output wire [31:0] readdata_out,
   output wire        waitrequest_out,
   input  wire [63:0] reading_in,           // Q48.16 reading
   input  wire        reading_valid_in,     // One-cycle pulse
   input  wire        reading_ovf_in,       // Reading overflowed
   input  wire [63:0] rel_value_in,         // Relative offset
   input  wire        rel_enable_in,
   input  wire        front_sel_in,         // Front inputs chosen
   input  wire        channel_closed_in,
   input  wire        scan_adv_in,          // Advanced scan active
   input  wire [IW-1:0] channel_in,         // Scanned channel
   output wire        math_led_out,
   output wire        result_valid_out      // One-cycle pulse
);
   // One-hot states of the result engine
   localparam ST_IDLE = 2'b01;
   localparam ST_DIV  = 2'b10;
   localparam [IW-1:0] ONE_IW = 1;

   // Per-entry configuration; entry 0 is the shared setup
   reg  [1:0]  sel_mem   [0:NCH];
   reg         en_mem    [0:NCH];
   reg  [7:0]  unit_mem  [0:NCH];
   reg  [63:0] scale_mem [0:NCH];
   reg  [63:0] offs_mem  [0:NCH];
   reg  [63:0] ref_mem   [0:NCH];

   reg  [IW-1:0] cfg_idx_ff;                // Bus target entry
   reg  [31:0] stage_ff;                    // Low word staging
   reg  [31:0] entry_ff;                    // Keyed-in digits
   reg  [1:0]  mult_ff;                     // Entry multiplier
   reg         esign_ff;                    // Entry polarity
   reg  [63:0] res_ff;                      // Last result
   reg  [7:0]  res_unit_ff;
   reg         res_ovf_ff;
   reg         fresh_ff;                    // Unread result
   reg  [63:0] last_x_ff;                   // Last rel-corrected reading
   reg         have_rd_ff;
   reg         last_ovf_ff;
   reg  [15:0] err_ff;
   reg  [1:0]  state_ff;
   reg  [95:0] dnum_ff;                     // Divider numerator
   reg  [63:0] dden_ff;                     // Divider denominator
   reg  [64:0] drem_ff;
   reg  [95:0] dq_ff;
   reg         dneg_ff;
   reg  [6:0]  dcnt_ff;
   reg  [7:0]  dunit_ff;
   reg  [31:0] rdata_ff;
   reg         wait_ff;
   reg         led_ff;
   reg         rvalid_ff;
   integer     i;

   // Clamp a wide value to the documented magnitude limit
   function [63:0] sat;
      input [95:0] v;
      begin
         if ($signed(v) > $signed({32'h0, `RM_LIM}))
            sat = `RM_LIM;
         else if ($signed(v) < -$signed({32'h0, `RM_LIM}))
            sat = -`RM_LIM;
         else
            sat = v[63:0];
      end
   endfunction

   // Active entry for the incoming reading
   wire [IW-1:0] act = scan_adv_in ? channel_in + ONE_IW : {IW{1'b0}};
   wire [1:0]  a_sel = sel_mem[act];
   wire        a_on  = en_mem[act] && (a_sel != `RM_SEL_NONE);
   wire [63:0] x = rel_enable_in ? reading_in - rel_value_in : reading_in;
   wire        take = reading_valid_in && (state_ff == ST_IDLE)
                      && (front_sel_in || channel_closed_in);

   // Scale and offset path; the full product keeps the sign,
   // and its bits 79 to 16 are the Q48.16 product
   wire [127:0] prod = $signed(scale_mem[act]) * $signed(x);
   wire [63:0]  so_val = prod[79:16] + offs_mem[act];

   // Percent numerator: (x - ref) * 100 in Q16, pre-shifted
   wire [64:0]  pdif = {x[63], x} - {ref_mem[act][63], ref_mem[act]};
   wire [95:0]  pmul = $signed({{31{pdif[64]}}, pdif}) * 96'sd100;
   wire [95:0]  pabs = pmul[95] ? -pmul : pmul;
   wire [63:0]  rabs = ref_mem[act][63] ? -ref_mem[act] : ref_mem[act];
   wire [63:0]  xabs = x[63] ? -x : x;

   // Entry value with multiplier and sign applied
   wire [95:0]  emag = {48'h0, entry_ff, 16'h0};
   reg  [95:0]  escl;
   always @* begin
      case (mult_ff)
         2'h0:    escl = emag / 96'd1000;
         2'h1:    escl = emag;
         2'h2:    escl = emag * 96'd1000;
         default: escl = emag * 96'd1000000;
      endcase
   end
   wire [63:0]  eval = sat(esign_ff ? -escl : escl);

   // Divider step
   wire [64:0]  rsh  = {drem_ff[63:0], dnum_ff[95]};
   wire         dge  = rsh >= {1'b0, dden_ff};

   // Bus request decode
   wire req    = read_in || write_in;
   wire wr_ok  = write_in && (byteenable_in == 4'hf);
   wire commit = req && !wait_ff;           // Edge the master samples
   wire [7:0] a = address_in;
   wire [31:0] wd = writedata_in;
   wire [63:0] wide = {wd, stage_ff};

   // Read data mux
   reg  [31:0] nxt_rdata;
   always @* begin
      if (a == `RM_CTRL)
         nxt_rdata = {28'h0, led_ff, en_mem[cfg_idx_ff], sel_mem[cfg_idx_ff]};
      else if (a == `RM_CFG_IDX)
         nxt_rdata = {{(32-IW){1'b0}}, cfg_idx_ff};
      else if (a == `RM_UNIT)
         nxt_rdata = {24'h0, unit_mem[cfg_idx_ff]};
      else if (a == `RM_SCALE_LO)
         nxt_rdata = scale_mem[cfg_idx_ff][31:0];
      else if (a == `RM_SCALE_HI)
         nxt_rdata = scale_mem[cfg_idx_ff][63:32];
      else if (a == `RM_OFFS_LO)
         nxt_rdata = offs_mem[cfg_idx_ff][31:0];
      else if (a == `RM_OFFS_HI)
         nxt_rdata = offs_mem[cfg_idx_ff][63:32];
      else if (a == `RM_REF_LO)
         nxt_rdata = ref_mem[cfg_idx_ff][31:0];
      else if (a == `RM_REF_HI)
         nxt_rdata = ref_mem[cfg_idx_ff][63:32];
      else if (a == `RM_ENTRY)
         nxt_rdata = entry_ff;
      else if (a == `RM_ENTRY_CTL)
         nxt_rdata = {29'h0, esign_ff, mult_ff};
      else if ((a == `RM_RES_LO) || (a == `RM_FRESH_LO))
         nxt_rdata = res_ff[31:0];
      else if ((a == `RM_RES_HI) || (a == `RM_FRESH_HI))
         nxt_rdata = res_ff[63:32];
      else if (a == `RM_STATUS)
         nxt_rdata = {err_ff, res_unit_ff, 4'h0, have_rd_ff,
                      (state_ff == ST_DIV), fresh_ff, res_ovf_ff};
      else
         nxt_rdata = 32'h0;                 // Unmapped reads as zero
   end

   // Bus handshake: one wait cycle, held while a result is computing
   // Holding off during a division keeps a read from seeing a half-built result
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0;
      end else if (commit) begin
         wait_ff  <= 1'b1;                  // Reassert after the sampled edge
      end else if (req && state_ff == ST_IDLE) begin
         wait_ff  <= 1'b0;
         rdata_ff <= nxt_rdata;
      end
   end

   // Configuration, commands, computation and result
   always @(posedge clk_in) begin
      rvalid_ff <= 1'b0;
      led_ff    <= en_mem[0] && (sel_mem[0] != `RM_SEL_NONE);
      if (!rst_n_in) begin
         for (i = 0; i <= NCH; i = i + 1) begin
            sel_mem[i]   <= `RM_SEL_PERC;
            en_mem[i]    <= 1'b0;
            unit_mem[i]  <= `RM_UNIT_DEF;
            scale_mem[i] <= `RM_ONE;
            offs_mem[i]  <= `RM_ZERO;
            ref_mem[i]   <= `RM_ONE;
         end
         cfg_idx_ff  <= {IW{1'b0}};
         stage_ff    <= 32'h0;
         entry_ff    <= 32'h0;
         mult_ff     <= 2'h1;
         esign_ff    <= 1'b0;
         res_ff      <= `RM_ZERO;
         res_unit_ff <= 8'h0;
         res_ovf_ff  <= 1'b0;
         fresh_ff    <= 1'b0;
         last_x_ff   <= `RM_ZERO;
         have_rd_ff  <= 1'b0;
         last_ovf_ff <= 1'b0;
         err_ff      <= `RM_ERR_NONE;
         state_ff    <= ST_IDLE;
         dnum_ff     <= 96'h0;
         dden_ff     <= 64'h0;
         drem_ff     <= 65'h0;
         dq_ff       <= 96'h0;
         dneg_ff     <= 1'b0;
         dcnt_ff     <= 7'h0;
         dunit_ff    <= 8'h0;
         led_ff      <= 1'b0;
      end else begin
         // Register writes take effect at the sampled edge
         if (commit && wr_ok) begin
            if (a == `RM_CTRL) begin
               sel_mem[cfg_idx_ff] <= wd[1:0];
               en_mem[cfg_idx_ff]  <= wd[2];
            end else if (a == `RM_CFG_IDX) begin
               if (wd[IW-1:0] <= NCH)
                  cfg_idx_ff <= wd[IW-1:0];
            end else if (a == `RM_UNIT) begin
               unit_mem[cfg_idx_ff] <= wd[7:0];
            end else if ((a == `RM_SCALE_LO) || (a == `RM_OFFS_LO)
                         || (a == `RM_REF_LO)) begin
               stage_ff <= wd;
            end else if (a == `RM_SCALE_HI) begin
               scale_mem[cfg_idx_ff] <= sat({{32{wd[31]}}, wide});
            end else if (a == `RM_OFFS_HI) begin
               offs_mem[cfg_idx_ff] <= sat({{32{wd[31]}}, wide});
            end else if (a == `RM_REF_HI) begin
               ref_mem[cfg_idx_ff] <= sat({{32{wd[31]}}, wide});
            end else if (a == `RM_ENTRY) begin
               entry_ff <= wd;
            end else if (a == `RM_ENTRY_CTL) begin
               mult_ff  <= wd[1:0];
               esign_ff <= wd[2];
            end else if (a == `RM_STATUS) begin
               err_ff <= `RM_ERR_NONE;      // Any write clears the error
            end else if (a == `RM_CMD) begin
               // Command bits act together; preset wins over reset
               if (wd[`RM_CMD_ACQ]) begin
                  if (!have_rd_ff || last_ovf_ff)
                     err_ff <= `RM_ERR_EXEC;
                  else
                     ref_mem[cfg_idx_ff] <= sat({{32{last_x_ff[63]}}, last_x_ff});
               end
               if (wd[`RM_CMD_RST])
                  for (i = 0; i <= NCH; i = i + 1)
                     en_mem[i] <= 1'b1;
               if (wd[`RM_CMD_PRESET])
                  for (i = 0; i <= NCH; i = i + 1)
                     en_mem[i] <= 1'b0;
               // Toggle follows the indicator, which lags the enable a cycle
               if (wd[`RM_CMD_MENU])
                  en_mem[0] <= !led_ff;
               if (wd[`RM_CMD_TOGSIGN])
                  esign_ff <= !esign_ff;
               if (wd[`RM_CMD_LDSCALE])
                  scale_mem[cfg_idx_ff] <= eval;
               if (wd[`RM_CMD_LDOFFS])
                  offs_mem[cfg_idx_ff] <= eval;
               if (wd[`RM_CMD_LDREF])
                  ref_mem[cfg_idx_ff] <= eval;
            end
         end
         // Fresh query: second read of the same result is stale
         if (commit && read_in && (a == `RM_FRESH_HI)) begin
            if (fresh_ff)
               fresh_ff <= 1'b0;
            else
               err_ff <= `RM_ERR_STALE;
         end
         case (state_ff)
            ST_IDLE: begin
               if (take) begin
                  last_x_ff   <= x;
                  last_ovf_ff <= reading_ovf_in;
                  have_rd_ff  <= 1'b1;
                  // Overflowed or unprocessed readings pass through
                  if (reading_ovf_in || !a_on) begin
                     res_ff      <= reading_in;
                     res_ovf_ff  <= reading_ovf_in;
                     res_unit_ff <= 8'h0;
                     fresh_ff    <= 1'b1;   // New reading beats a clear
                     rvalid_ff   <= 1'b1;
                  end else if (a_sel == `RM_SEL_SCALE_OFFSET) begin
                     // Scale and offset completes in the taking cycle
                     res_ff      <= so_val;
                     res_ovf_ff  <= 1'b0;
                     res_unit_ff <= unit_mem[act];
                     fresh_ff    <= 1'b1;
                     rvalid_ff   <= 1'b1;
                  end else if (a_sel == `RM_SEL_PERC) begin
                     // Magnitudes are divided; the sign is kept aside
                     dnum_ff  <= {pabs[79:0], 16'h0};
                     dden_ff  <= rabs;
                     dneg_ff  <= pmul[95] ^ ref_mem[act][63];
                     dunit_ff <= `RM_UNIT_PCT;
                     drem_ff  <= 65'h0;
                     dq_ff    <= 96'h0;
                     dcnt_ff  <= `RM_DIV_LEN;
                     state_ff <= ST_DIV;
                  end else begin
                     // 1.0 pre-shifted by the fraction width, so that the
                     // quotient comes out in Q48.16 like the reading
                     dnum_ff  <= {32'h0, `RM_ONE} << `RM_FRAC;
                     dden_ff  <= xabs;
                     dneg_ff  <= x[63];
                     dunit_ff <= `RM_UNIT_RCP;
                     drem_ff  <= 65'h0;
                     dq_ff    <= 96'h0;
                     dcnt_ff  <= `RM_DIV_LEN;
                     state_ff <= ST_DIV;
                  end
               end
            end
            ST_DIV: begin
               // Restoring division, one quotient bit a cycle
               dnum_ff <= {dnum_ff[94:0], 1'b0};
               drem_ff <= dge ? rsh - {1'b0, dden_ff} : rsh;
               dq_ff   <= {dq_ff[94:0], dge};
               dcnt_ff <= dcnt_ff - 7'h1;
               if (dcnt_ff == 7'h1) begin
                  // Zero divisor or too large a quotient is overflow
                  res_ovf_ff <= (dden_ff == 64'h0)
                                || ({dq_ff[94:0], dge} > {33'h0, 63'h7fff_ffff_ffff_ffff});
                  // Quotient magnitude gets its sign back
                  if (dneg_ff)
                     res_ff <= -{dq_ff[62:0], dge};
                  else
                     res_ff <= {dq_ff[62:0], dge};
                  res_unit_ff <= dunit_ff;
                  fresh_ff    <= 1'b1;
                  rvalid_ff   <= 1'b1;
                  state_ff    <= ST_IDLE;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   assign readdata_out     = rdata_ff;
   assign waitrequest_out  = wait_ff;
   assign math_led_out     = led_ff;
   assign result_valid_out = rvalid_ff;
endmodule // reading_math_postprocessor
`default_nettype wire

// ---- testbench/reading_math_assertions.sv ----
// Port-level assertions for the reading math post-processor
`default_nettype none
module reading_math_assertions (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [7:0]  address_in,
   input wire logic        read_in,
   input wire logic        write_in,
   input wire logic [31:0] writedata_in,
   input wire logic [3:0]  byteenable_in,
   input wire logic        waitrequest_out,
   input wire logic        reading_valid_in,
   input wire logic        math_led_out,
   input wire logic        result_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Full-word write to the command register at its accept edge
   sequence s_cmd_wr;
      write_in && !waitrequest_out && address_in == 8'h04 && byteenable_in == 4'hf;
   endsequence
   // Menu toggle while the indicator is lit
   sequence s_menu_lit;
      math_led_out ##0 s_cmd_wr ##0 writedata_in[3];
   endsequence
   // Preset command accepted
   sequence s_preset;
      s_cmd_wr ##0 writedata_in[2];
   endsequence
   chk_reset_idle: assert property (disable iff (1'b0)
      !rst_n_in |=> waitrequest_out && !math_led_out && !result_valid_out)
      else $error("outputs not idle after reset");
   chk_wait_one: assert property (
      !waitrequest_out |=> waitrequest_out)
      else $error("waitrequest low for more than one cycle");
   chk_wait_cause: assert property (
      !waitrequest_out |-> read_in || write_in)
      else $error("answer without a request");
   chk_wait_bound: assert property (
      (read_in || write_in) && waitrequest_out |-> ##[0:100] !waitrequest_out)
      else $error("request not answered in time");
   chk_result_once: assert property (
      result_valid_out |=> !result_valid_out)
      else $error("result pulse longer than one cycle");
   chk_result_cause: assert property (
      result_valid_out |-> $past(reading_valid_in) || $past(reading_valid_in, 97))
      else $error("result without a reading at the expected distance");
   chk_menu_off: assert property (
      s_menu_lit |-> ##2 !math_led_out)
      else $error("menu toggle left the indicator lit");
   chk_preset_off: assert property (
      s_preset |-> ##2 !math_led_out)
      else $error("preset left the indicator lit");
   chk_led_cause: assert property (
      !$stable(math_led_out) |-> $past(write_in, 2))
      else $error("indicator changed without a write");
endmodule // reading_math_assertions
bind reading_math_postprocessor reading_math_assertions reading_math_assertions_inst (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .address_in(address_in), .read_in(read_in),
   .write_in(write_in), .writedata_in(writedata_in), .byteenable_in(byteenable_in),
   .waitrequest_out(waitrequest_out), .reading_valid_in(reading_valid_in),
   .math_led_out(math_led_out), .result_valid_out(result_valid_out));
`default_nettype wire

// ---- testbench/host_bus_model.sv ----
// Host model: register bus master that issues commands and queries
`default_nettype none
module host_bus_model (
   input  wire logic        clk_in,
   input  wire logic        waitrequest_in,
   output var  logic [7:0]  address_out,
   output var  logic        read_out,
   output var  logic        write_out,
   output var  logic [31:0] writedata_out,
   output var  logic [3:0]  byteenable_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial begin
      address_out = 8'h00;
      read_out = 1'b0;
      write_out = 1'b0;
      writedata_out = 32'h0;
      byteenable_out = 4'hf;
   end
   // One transfer, held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic ok);
      int n;
      n = 0;
      @(posedge clk_in);
      address_out <= a;
      writedata_out <= wr ? d : 32'h0;
      write_out <= wr;
      read_out <= !wr;
      ok = 1'b0;
      // Waitrequest is read as it stood at the edge; slow answers are bounded
      while (!ok && n < 300) begin
         @(posedge clk_in);
         n++;
         ok = !waitrequest_in;
      end
      read_out <= 1'b0;
      write_out <= 1'b0;
   endtask
endmodule // host_bus_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the reading math post-processor
`default_nettype none
`include "reading_math_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in = 1'b0;        // 250 MHz clock
   logic        rst_n_in = 1'b0;      // Synchronous reset
   logic [63:0] reading_in = '0;      // Measurement reading
   logic        reading_valid_in = 1'b0;
   logic        reading_ovf_in = 1'b0;
   logic [63:0] rel_value_in = `RM_ONE;
   logic        rel_enable_in = 1'b0;
   logic        front_sel_in = 1'b1;
   logic        channel_closed_in = 1'b0;
   logic        scan_adv_in = 1'b0;
   logic [2:0]  channel_in = 3'h0;
   wire  [7:0]  address;             // Bus from the host model
   wire         rd_req;
   wire         wr_req;
   wire  [31:0] wdata;
   wire  [3:0]  benable;
   wire  [31:0] rdata;
   wire         waitreq;
   wire         math_led_out;
   wire         result_valid_out;
   logic [63:0] exp_q[$];            // Expected reads as mask and value
   logic [63:0] e;
   logic [31:0] seed = 32'h9f0f;     // Random source state
   int          fail_count = 0;
   int          n_checks = 0;
   int          cycles = 0;
   logic [31:0] ent[4] = '{32'd1000, 32'd3, 32'd2, 32'd5000};
   logic [63:0] sc[4] = '{`RM_ONE, 64'h3_0000, 64'h7d0_0000, `RM_LIM};
   host_bus_model host_bus_model_inst (.clk_in(clk_in), .waitrequest_in(waitreq),
      .address_out(address), .read_out(rd_req), .write_out(wr_req),
      .writedata_out(wdata), .byteenable_out(benable));
   reading_math_postprocessor reading_math_postprocessor_inst (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .address_in(address), .read_in(rd_req), .write_in(wr_req),
      .writedata_in(wdata), .byteenable_in(benable), .readdata_out(rdata),
      .waitrequest_out(waitreq), .reading_in(reading_in),
      .reading_valid_in(reading_valid_in), .reading_ovf_in(reading_ovf_in),
      .rel_value_in(rel_value_in), .rel_enable_in(rel_enable_in),
      .front_sel_in(front_sel_in), .channel_closed_in(channel_closed_in),
      .scan_adv_in(scan_adv_in), .channel_in(channel_in),
      .math_led_out(math_led_out), .result_valid_out(result_valid_out));
   always #2 clk_in = ~clk_in;
   // Step the random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Compare and count
   task automatic check(input string what, input logic [31:0] x, input logic [31:0] got);
      n_checks++;
      if (got !== x) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, x, got);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Each answered read takes the oldest note
   always @(posedge clk_in) begin
      if (rd_req && !waitreq && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("readdata", e[31:0], rdata & e[63:32]);
      end
   end
   // Hang guard
   always @(posedge clk_in) begin
      cycles++;
      if (cycles > 20000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ok;
      host_bus_model_inst.xfer(1'b1, a, d, ok);
      check("write wait", 32'h1, {31'h0, ok});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
      logic ok;
      exp_q.push_back({m, x & m});
      host_bus_model_inst.xfer(1'b0, a, 32'h0, ok);
      check("read wait", 32'h1, {31'h0, ok});
   endtask
   task automatic rd64(input logic [7:0] a, input logic [63:0] x);
      rd(a, x[31:0], 32'hffff_ffff);
      rd(a + 8'h4, x[63:32], 32'hffff_ffff);
   endtask
   task automatic wr64(input logic [7:0] a, input logic [63:0] x);
      wr(a, x[31:0]);
      wr(a + 8'h4, x[63:32]);
   endtask
   // One reading pulse, then wait for its result
   task automatic meas(input logic [63:0] v);
      int n;
      n = 0;
      reading_in <= v;
      reading_valid_in <= 1'b1;
      @(posedge clk_in);
      reading_valid_in <= 1'b0;
      @(negedge clk_in);
      while (!result_valid_out && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      check("result pulse", 32'h1, {31'h0, n < 200});
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(`RM_CTRL, 32'h2, 32'hf);
      rd64(`RM_REF_LO, `RM_ONE);
      rd64(`RM_SCALE_LO, `RM_ONE);
      rd64(`RM_OFFS_LO, `RM_ZERO);
      wr(`RM_CMD, 32'h1);
      rd(`RM_STATUS, 32'hff38_0000, 32'hffff_0000);
      wr(`RM_STATUS, 32'h0);
      wr(`RM_CMD, 32'h2);
      rd(`RM_CTRL, 32'hc, 32'hc);
      wr(`RM_CTRL, 32'h4);
      rel_enable_in <= 1'b1;
      // Random raw readings come back untouched
      for (int i = 0; i < 3; i++) begin
         seed = lfsr(seed);
         meas({32'h0, seed});
         rd64(`RM_RES_LO, {32'h0, seed});
         rd64(`RM_FRESH_LO, {32'h0, seed});
      end
      wr64(`RM_SCALE_LO, 64'h2_0000);
      wr64(`RM_OFFS_LO, 64'h64_0000);
      wr(`RM_UNIT, 32'h5b);
      wr(`RM_CTRL, 32'h5);
      rel_enable_in <= 1'b0;
      meas(64'h3_0000);
      rd64(`RM_RES_LO, 64'h6a_0000);
      rd(`RM_STATUS, 32'h5b00, 32'hff00);
      wr64(`RM_REF_LO, 64'h1_0000_0000_0000);
      rd64(`RM_REF_LO, `RM_LIM);
      wr64(`RM_REF_LO, 64'h2_0000);
      rd64(`RM_REF_LO, 64'h2_0000);
      wr(`RM_CTRL, 32'h6);
      rel_enable_in <= 1'b1;
      meas(64'h4_0000);
      rd64(`RM_RES_LO, 64'h32_0000);
      rd(`RM_STATUS, 32'h2500, 32'hff00);
      meas(64'h2_0000);
      rd64(`RM_FRESH_LO, 64'hffff_ffff_ffce_0000);
      rd(`RM_FRESH_HI, 32'h0, 32'h0);
      rd(`RM_STATUS, 32'hff1a_0000, 32'hffff_0002);
      rd64(`RM_RES_LO, 64'hffff_ffff_ffce_0000);
      wr(`RM_STATUS, 32'h0);
      wr(`RM_CMD, 32'h1);
      rd64(`RM_REF_LO, `RM_ONE);
      reading_ovf_in <= 1'b1;
      meas(64'h5_0000);
      reading_ovf_in <= 1'b0;
      wr(`RM_CMD, 32'h1);
      rd(`RM_STATUS, 32'hff38_0000, 32'hffff_0000);
      wr(`RM_STATUS, 32'h0);
      wr(`RM_CTRL, 32'h7);
      meas(64'h3_0000);
      rd64(`RM_RES_LO, 64'h8000);
      rd(`RM_STATUS, 32'h5200, 32'hff00);
      meas(64'h1_0000);
      rd(`RM_STATUS, 32'h1, 32'h1);
      wr(`RM_CMD, 32'h8);
      rd(`RM_CTRL, 32'h3, 32'hf);
      check("led", 32'h0, {31'h0, math_led_out});
      wr(`RM_CMD, 32'h8);
      rd(`RM_CTRL, 32'hf, 32'hf);
      // Every entry multiplier, the last one saturating
      for (int i = 0; i < 4; i++) begin
         wr(`RM_ENTRY, ent[i]);
         wr(`RM_ENTRY_CTL, i);
         wr(`RM_CMD, 32'h20);
         rd64(`RM_SCALE_LO, sc[i]);
      end
      wr(`RM_ENTRY, 32'd3);
      wr(`RM_ENTRY_CTL, 32'h1);
      wr(`RM_CMD, 32'h10);
      wr(`RM_CMD, 32'h40);
      rd64(`RM_OFFS_LO, 64'hffff_ffff_fffd_0000);
      wr(`RM_CMD, 32'h4);
      rd(`RM_CTRL, 32'h0, 32'hc);
      wr(`RM_CMD, 32'h2);
      wr(`RM_CFG_IDX, 32'h1);
      wr(`RM_CTRL, 32'h4);
      wr(`RM_CFG_IDX, 32'h0);
      rel_enable_in <= 1'b0;
      front_sel_in <= 1'b0;
      channel_closed_in <= 1'b1;
      scan_adv_in <= 1'b1;
      channel_in <= 3'h0;
      meas(64'h2_0000);
      rd64(`RM_RES_LO, 64'h2_0000);
      scan_adv_in <= 1'b0;
      meas(64'h2_0000);
      rd64(`RM_RES_LO, 64'h8000);
      rd(8'h80, 32'h0, 32'hffff_ffff);
      @(posedge clk_in);
      check("pending reads", 32'h0, exp_q.size());
      conclude();
   end
endmodule // testbench
`default_nettype wire
